// *** hw/sar_adc_serial_readout.sv ***
// conversion control and serial readout of an eight-channel 14-bit converter
// assumes csN, sck and the select pins come straight from the host's pins
`timescale 1ns/1ps
module sar_adc_serial_readout (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic csN,
	input wire logic sck,
	input wire logic [sar_pkg::NUM_CH*sar_pkg::RES_W-1:0] analogIn,
	input wire logic [sar_pkg::SEL_W-1:0] channelSelectPins,
	input wire logic [sar_pkg::SEL_W-1:0] gainSelectPins,
	input wire logic gainStageBypass,
	input wire logic lowPowerSelect,
	output logic busy,
	output logic sdo,
	output logic sdoOe,
	output logic resultValid
);
	// gain of the stage for each select code, as a plain multiplier
	function automatic logic [sar_pkg::CNT_W-1:0] gainFactor(
		input logic [sar_pkg::SEL_W-1:0] code
	);
		case (code)
			3'h0: gainFactor = 5'h01;
			3'h1: gainFactor = 5'h02;
			3'h2: gainFactor = 5'h03;
			3'h3: gainFactor = 5'h04;
			3'h4: gainFactor = 5'h06;
			3'h5: gainFactor = 5'h08;
			3'h6: gainFactor = 5'h0C;
			default: gainFactor = 5'h10;
		endcase
	endfunction : gainFactor

	// scaled sample saturates at full scale rather than wrapping
	function automatic logic [sar_pkg::RES_W-1:0] applyGain(
		input logic [sar_pkg::RES_W-1:0] level,
		input logic [sar_pkg::SEL_W-1:0] code,
		input logic bypass
	);
		logic [sar_pkg::RES_W+sar_pkg::CNT_W-1:0] prod;
		prod = level * gainFactor(code);
		if (bypass)
			applyGain = level;
		else if (prod > {{sar_pkg::CNT_W{1'b0}}, sar_pkg::RESULT_MAX})
			applyGain = sar_pkg::RESULT_MAX;
		else
			applyGain = prod[sar_pkg::RES_W-1:0];
	endfunction : applyGain

	function automatic logic [sar_pkg::CNT_W-1:0] binToGray(
		input logic [sar_pkg::CNT_W-1:0] bin
	);
		binToGray = bin ^ (bin >> 1);
	endfunction : binToGray

	function automatic logic [sar_pkg::CNT_W-1:0] grayToBin(
		input logic [sar_pkg::CNT_W-1:0] gray
	);
		logic [sar_pkg::CNT_W-1:0] bin;
		bin = '0;
		bin[sar_pkg::CNT_W-1] = gray[sar_pkg::CNT_W-1];
		for (int i = sar_pkg::CNT_W - 2; i >= 0; i--) begin
			bin[i] = gray[i] ^ bin[i+1];
		end
		grayToBin = bin;
	endfunction : grayToBin

	// reset release through two flip-flops
	logic [1:0] rstPipe;
	wire rstN = rstPipe[1];
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn)
			rstPipe <= 2'b00;
		else
			rstPipe <= {rstPipe[0], 1'b1};
	end

	// pin synchronisers; every pin passes two stages before any core_clk logic (sck and csN drive the link counter directly)
	// the analog levels settle long before a start, so that bus needs no handshake
	localparam int SEL_BUS_W = 2 * sar_pkg::SEL_W + 2;
	localparam int AN_W = sar_pkg::NUM_CH * sar_pkg::RES_W;
	logic csMeta;
	logic csSync;
	logic csPrev;
	logic [SEL_BUS_W-1:0] selMeta;
	logic [SEL_BUS_W-1:0] selSync;
	logic [AN_W-1:0] anMeta;
	logic [AN_W-1:0] anSync;
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			csMeta <= 1'b1;
			csSync <= 1'b1;
			csPrev <= 1'b1;
			selMeta <= '0;
			selSync <= '0;
			anMeta <= '0;
			anSync <= '0;
		end else begin
			csMeta <= csN;
			csSync <= csMeta;
			csPrev <= csSync;
			selMeta <= {lowPowerSelect, gainStageBypass, gainSelectPins, channelSelectPins};
			selSync <= selMeta;
			anMeta <= analogIn;
			anSync <= anMeta;
		end
	end
	// csPrev is a third stage, so each edge is seen once and on settled levels
	wire csFall = csPrev && !csSync;
	wire csRise = !csPrev && csSync;

	// link side: bit counter on the serial clock, cleared while chip select is high
	// the clear moves several gray bits at once; csRise masks the readout meanwhile
	logic [sar_pkg::CNT_W-1:0] linkBin;
	logic [sar_pkg::CNT_W-1:0] linkGray;
	wire linkFull = linkBin == sar_pkg::WORD_BITS;
	wire [sar_pkg::CNT_W-1:0] next_linkBin = linkFull ? linkBin : linkBin + 1'b1;
	always_ff @(posedge sck or posedge csN) begin
		if (csN) begin
			linkBin <= '0;
			linkGray <= '0;
		end else begin
			linkBin <= next_linkBin;
			linkGray <= binToGray(next_linkBin);
		end
	end

	// gray count crosses into core_clk; one bit changes per sck edge so a torn read cannot occur while counting
	logic [sar_pkg::CNT_W-1:0] grayMeta;
	logic [sar_pkg::CNT_W-1:0] graySync;
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			grayMeta <= '0;
			graySync <= '0;
		end else begin
			grayMeta <= linkGray;
			graySync <= grayMeta;
		end
	end
	wire [sar_pkg::CNT_W-1:0] shiftIdx = grayToBin(graySync);

	// channel, gain and bypass selections latched at chip select rising, used by the conversion that follows
	logic [sar_pkg::SEL_W-1:0] latChan;
	logic [sar_pkg::SEL_W-1:0] latGain;
	logic latBypass;
	logic latLowPower;
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			latChan <= sar_pkg::SEL_RST;
			latGain <= sar_pkg::SEL_RST;
			latBypass <= 1'b0;
		end else if (csRise) begin
			latChan <= selSync[sar_pkg::SEL_W-1:0];
			latGain <= selSync[2*sar_pkg::SEL_W-1:sar_pkg::SEL_W];
			latBypass <= selSync[2*sar_pkg::SEL_W];
		end
	end

	// channel multiplexer followed by the gain stage
	wire [sar_pkg::RES_W-1:0] chanLevel = anSync[latChan*sar_pkg::RES_W +: sar_pkg::RES_W];
	wire [sar_pkg::RES_W-1:0] stageLevel = applyGain(chanLevel, latGain, latBypass);

	// the engine always finishes inside the shorter bypass count
	sar_conv_if conv ();
	sar_approx_engine engine (
		.clk(core_clk),
		.rstN(rstN),
		.conv(conv)
	);

	sar_pkg::sar_state_t state;
	sar_pkg::sar_state_t next_state;
	logic [sar_pkg::CONV_W-1:0] convCnt;
	logic resultReady;
	logic primed;
	logic [sar_pkg::WORD_W-1:0] word;

	// conversion length set by whether the gain stage is in the path
	wire [sar_pkg::CONV_W-1:0] convLen = latBypass ? sar_pkg::CONV_BYPASS_CYC :
		sar_pkg::CONV_GAIN_CYC;
	// done is a one-cycle pulse; resultReady keeps it until the count runs out
	wire convOver = (convCnt == '0) && (resultReady || conv.done);
	wire startConv = (state == sar_pkg::SAR_ACQUIRE) && csFall;
	wire loadWord = (state == sar_pkg::SAR_CONVERT) && convOver && !csRise;
	logic [sar_pkg::RES_W-1:0] engineResult;
	wire [sar_pkg::RES_W-1:0] freshResult = conv.done ? conv.result : engineResult;
	// first result after reset, when taken in normal mode, has no settled front end, so it is flagged
	wire firstInvalid = !primed && !latLowPower;
	wire [sar_pkg::RES_W-1:0] shownResult = firstInvalid ? sar_pkg::RESULT_RST : freshResult;
	wire [sar_pkg::WORD_W-1:0] next_word = {shownResult, latChan, latGain};
	wire [sar_pkg::CNT_W-1:0] bitPos = sar_pkg::WORD_BITS - 1'b1 - shiftIdx;
	wire shiftBit = (shiftIdx < sar_pkg::WORD_BITS) ? word[bitPos] : 1'b0;

	assign conv.start = startConv;
	assign conv.sample = stageLevel;

	always_comb begin
		next_state = state;
		case (state)
			sar_pkg::SAR_ACQUIRE: begin
				if (csFall)
					next_state = sar_pkg::SAR_CONVERT;
			end
			sar_pkg::SAR_CONVERT: begin
				if (csRise)
					next_state = sar_pkg::SAR_ACQUIRE;
				else if (convOver)
					next_state = sar_pkg::SAR_READOUT;
			end
			sar_pkg::SAR_READOUT: begin
				if (csRise)
					next_state = sar_pkg::SAR_ACQUIRE;
			end
			default: next_state = sar_pkg::SAR_ACQUIRE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			state <= sar_pkg::SAR_ACQUIRE;
			convCnt <= '0;
			resultReady <= 1'b0;
			engineResult <= sar_pkg::RESULT_RST;
		end else begin
			state <= next_state;
			if (startConv)
				convCnt <= convLen - 1'b1;
			else if (convCnt != '0)
				convCnt <= convCnt - 1'b1;
			if (startConv)
				resultReady <= 1'b0;
			else if (conv.done)
				resultReady <= 1'b1;
			if (conv.done)
				engineResult <= conv.result;
		end
	end

	// readout word and validity
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			word <= sar_pkg::WORD_RST;
			primed <= 1'b0;
			resultValid <= 1'b0;
			latLowPower <= 1'b0;
		end else begin
			if (loadWord) begin
				word <= next_word;
				primed <= 1'b1;
				resultValid <= !firstInvalid;
			end else if (startConv) begin
				resultValid <= 1'b0;
			end
			// mode taken at the start, so the first conversion after reset already sees it
			if (startConv)
				latLowPower <= selSync[2*sar_pkg::SEL_W+1];
		end
	end

	// pin outputs; the host keeps sck low during busy so the count still reads zero at load
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			busy <= 1'b0;
			sdo <= 1'b0;
			sdoOe <= 1'b0;
		end else begin
			sdoOe <= !csSync;
			if (startConv)
				busy <= 1'b1;
			else if (loadWord || csRise)
				busy <= 1'b0;
			// csRise wins: the bit count is clearing and may point anywhere
			if (loadWord)
				sdo <= next_word[sar_pkg::WORD_W-1];
			else if (state == sar_pkg::SAR_READOUT && !csRise)
				sdo <= shiftBit;
			else
				sdo <= 1'b0;
		end
	end
endmodule : sar_adc_serial_readout

// *** hw/sar_pkg.sv ***
// constants and types shared by the converter control and the approximation engine
// assumes core_clk at 25 MHz; all pin-facing figures are derived from that rate
package sar_pkg;
	localparam int RES_W = 14;
	localparam int SEL_W = 3;
	localparam int NUM_CH = 8;
	localparam int WORD_W = RES_W + 2 * SEL_W;
	localparam int CNT_W = 5;
	localparam int CONV_W = 6;
	localparam int IDX_W = 4;
	localparam int CLK_PERIOD_NS = 40;
	localparam int CONV_BYPASS_NS = 660;
	localparam int CONV_GAIN_NS = 1550;
	// longest times round down to whole cycles, never below one
	localparam int CONV_BYPASS_CYC_I = (CONV_BYPASS_NS / CLK_PERIOD_NS < 1) ? 1 :
		CONV_BYPASS_NS / CLK_PERIOD_NS;
	localparam int CONV_GAIN_CYC_I = (CONV_GAIN_NS / CLK_PERIOD_NS < 1) ? 1 :
		CONV_GAIN_NS / CLK_PERIOD_NS;
	localparam logic [CONV_W-1:0] CONV_BYPASS_CYC = CONV_BYPASS_CYC_I[CONV_W-1:0];
	localparam logic [CONV_W-1:0] CONV_GAIN_CYC = CONV_GAIN_CYC_I[CONV_W-1:0];
	localparam logic [CNT_W-1:0] WORD_BITS = 5'h14;
	localparam logic [IDX_W-1:0] MSB_IDX = 4'hD;
	localparam logic [RES_W-1:0] RESULT_RST = 14'h0000;
	localparam logic [RES_W-1:0] RESULT_MAX = 14'h3FFF;
	localparam logic [WORD_W-1:0] WORD_RST = 20'h00000;
	localparam logic [SEL_W-1:0] SEL_RST = 3'h0;
	typedef enum logic [1:0] {
		SAR_ACQUIRE = 2'b00,
		SAR_CONVERT = 2'b01,
		SAR_READOUT = 2'b10
	} sar_state_t;
endpackage : sar_pkg

// *** hw/sar_conv_if.sv ***
// start, held sample and finished result between the control and the engine
// assumes both ends run on core_clk
`timescale 1ns/1ps
interface sar_conv_if;
	logic start;
	logic [sar_pkg::RES_W-1:0] sample;
	logic done;
	logic [sar_pkg::RES_W-1:0] result;
	modport ctrl (output start, output sample, input done, input result);
	modport engine (input start, input sample, output done, output result);
endinterface : sar_conv_if

// *** hw/sar_approx_engine.sv ***
// successive approximation engine: one trial bit per core_clk cycle
// assumes a start pulse with a held sample; answers with a one-cycle done
`timescale 1ns/1ps
module sar_approx_engine (
	input wire logic clk,
	input wire logic rstN,
	sar_conv_if.engine conv
);
	logic [sar_pkg::RES_W-1:0] held;
	logic [sar_pkg::RES_W-1:0] approx;
	logic [sar_pkg::IDX_W-1:0] bitIdx;
	logic running;
	logic done;
	logic [sar_pkg::RES_W-1:0] result;
	wire [sar_pkg::RES_W-1:0] trial = approx | (sar_pkg::RES_W'(1) << bitIdx);
	wire keepBit = trial <= held;
	wire [sar_pkg::RES_W-1:0] next_approx = keepBit ? trial : approx;
	wire lastStep = running && (bitIdx == '0);

	assign conv.done = done;
	assign conv.result = result;

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			held <= sar_pkg::RESULT_RST;
			approx <= sar_pkg::RESULT_RST;
			bitIdx <= '0;
			running <= 1'b0;
			done <= 1'b0;
			result <= sar_pkg::RESULT_RST;
		end else if (conv.start) begin
			held <= conv.sample;
			approx <= sar_pkg::RESULT_RST;
			bitIdx <= sar_pkg::MSB_IDX;
			running <= 1'b1;
			done <= 1'b0;
		end else begin
			done <= lastStep;
			if (running) begin
				approx <= next_approx;
				bitIdx <= bitIdx - 1'b1;
			end
			if (lastStep) begin
				running <= 1'b0;
				result <= next_approx;
			end
		end
	end
endmodule : sar_approx_engine

// *** verification/sar_readout_monitor.sv ***
// pin-level assertions for the converter readout block
// assumes the bind at the foot; every check runs on core_clk
`timescale 1ns/1ps
module sar_readout_monitor (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic csN,
	input wire logic sck,
	input wire logic busy,
	input wire logic sdo,
	input wire logic sdoOe,
	input wire logic resultValid
);
	logic [5:0] busyLen;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			busyLen <= 6'h00;
		end else begin
			busyLen <= busy ? busyLen + 6'h01 : 6'h00;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// six samples leave room for the two-flop crossing of chip select
	sequence csIdle;
		csN [*6];
	endsequence
	sequence startSeen;
		!busy ##1 busy;
	endsequence
	a_conv_length: assert property ($fell(busy) && !csN |->
		(busyLen == sar_pkg::CONV_BYPASS_CYC || busyLen == sar_pkg::CONV_GAIN_CYC))
		else $error("conversion length wrong");
	a_idle_float: assert property (csIdle |-> !sdoOe)
		else $error("data pin driven while deselected");
	a_idle_no_conv: assert property (csIdle |-> !busy)
		else $error("busy while deselected");
	a_start_needs_cs: assert property (startSeen |-> !csN && !$past(csN))
		else $error("conversion without chip select fall");
	a_oe_with_busy: assert property (startSeen |-> ##[0:3] sdoOe)
		else $error("data pin not driven after start");
	a_busy_drives_low: assert property (busy && sdoOe |-> !sdo)
		else $error("data pin not low during conversion");
	a_valid_at_end: assert property ($rose(resultValid) |-> $fell(busy))
		else $error("valid rose away from busy fall");
	a_valid_clear: assert property (busy ##1 busy |-> !resultValid)
		else $error("valid held into new conversion");
	a_sdo_moves: assert property ($changed(sdo) && sdoOe && $past(sdoOe) && !$fell(busy) |->
		$past(sck) || $past(sck, 2) || $past(sck, 3) || $past(sck, 4))
		else $error("data pin moved without clock edge");
endmodule : sar_readout_monitor
bind sar_adc_serial_readout sar_readout_monitor i_sar_readout_monitor (.core_clk(core_clk),
	.resetn(resetn), .csN(csN), .sck(sck), .busy(busy), .sdo(sdo), .sdoOe(sdoOe),
	.resultValid(resultValid));

// *** verification/sar_host_model.sv ***
// host serial master: chip select, gated serial clock, msb-first capture
// assumes busy and the data pin come straight from the converter
`timescale 1ns/1ps
module sar_host_model (
	output logic csN,
	output wire logic sck,
	input wire logic busy,
	input wire logic sdo
);
	logic linkClk = 1'b0;
	logic sckEn = 1'b0;
	initial csN = 1'b1;
	initial begin
		#17;
		forever #62.5 linkClk = ~linkClk;
	end
	// enable only moves while linkClk is low, so sck never glitches
	assign sck = linkClk & sckEn;
	task automatic frame(input int edges, input bit abortIt, output logic [20:0] word);
		int n;
		word = 21'h000000;
		@(negedge linkClk);
		csN <= 1'b0;
		for (n = 0; n < 40 && busy !== 1'b1; n++) @(posedge linkClk);
		if (!abortIt) begin
			for (n = 0; n < 40 && busy !== 1'b0; n++) @(posedge linkClk);
			@(negedge linkClk);
			sckEn <= 1'b1;
			for (n = 0; n < edges; n++) begin
				@(posedge linkClk);
				word[20 - n] = sdo;
			end
			@(negedge linkClk);
			sckEn <= 1'b0;
			@(posedge linkClk);
			word[20 - edges] = sdo;
		end
		@(negedge linkClk);
		csN <= 1'b1;
		repeat (5) @(posedge linkClk);
	endtask : frame
endmodule : sar_host_model

// *** verification/tb_sar_adc_serial_readout.sv ***
// self-checking bench for the converter readout block
// assumes the host model leaves chip select high after each frame
`timescale 1ns/1ps
module tb_sar_adc_serial_readout;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic csN;
	wire logic sck;
	logic [sar_pkg::NUM_CH*sar_pkg::RES_W-1:0] analogIn = 112'h0;
	logic [sar_pkg::SEL_W-1:0] channelSelectPins = 3'h0;
	logic [sar_pkg::SEL_W-1:0] gainSelectPins = 3'h0;
	logic gainStageBypass = 1'b0;
	logic lowPowerSelect = 1'b0;
	logic busy, sdo, sdoOe, resultValid;
	// an undriven pin reads back inverted, so a missing enable cannot pass
	wire logic sdoPin = sdoOe ? sdo : !sdo;
	logic [2:0] latCh = 3'h0;
	logic [2:0] latG = 3'h0;
	logic latBy = 1'b0;
	logic [4:0] gainTab [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h10};
	int miscompares = 0;
	int comparisons = 0;
	initial forever #20 core_clk = ~core_clk;
	sar_adc_serial_readout i_sar_adc_serial_readout (.core_clk(core_clk), .resetn(resetn),
		.csN(csN), .sck(sck), .analogIn(analogIn), .channelSelectPins(channelSelectPins),
		.gainSelectPins(gainSelectPins), .gainStageBypass(gainStageBypass),
		.lowPowerSelect(lowPowerSelect), .busy(busy), .sdo(sdo), .sdoOe(sdoOe),
		.resultValid(resultValid));
	sar_host_model i_sar_host_model (.csN(csN), .sck(sck), .busy(busy), .sdo(sdoPin));
	task automatic test_done;
		if (miscompares == 0 && comparisons > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : test_done
	task automatic chk_word(input logic [20:0] exp, input logic [20:0] got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %0t word %h expected %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_bit(input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %0t valid flag %b expected %b", $time, got, exp);
		end
	endtask : chk_bit
	// one frame; select pins set here are latched at its rise and used by the next frame
	task automatic run(input logic [2:0] ch, input logic [2:0] g, input logic by,
		input logic [13:0] base, input int edges, input bit abortIt, input logic validExp);
		logic [20:0] got;
		logic [20:0] exp;
		logic [18:0] prod;
		logic [13:0] lvl;
		@(posedge core_clk);
		for (int k = 0; k < 8; k++) analogIn[k*14 +: 14] <= base + 14'(k * 16);
		channelSelectPins <= ch;
		gainSelectPins <= g;
		gainStageBypass <= by;
		repeat (2) @(posedge core_clk);
		lvl = base + {7'h00, latCh, 4'h0};
		prod = lvl * gainTab[latG];
		exp[20:7] = latBy ? lvl : (prod > 19'h03FFF ? 14'h3FFF : prod[13:0]);
		if (!validExp) exp[20:7] = 14'h0000;
		exp[6:0] = {latCh, latG, 1'b0};
		i_sar_host_model.frame(edges, abortIt, got);
		if (!abortIt) begin
			chk_word(exp & (~21'h0 << (20 - edges)), got);
			chk_bit(validExp, resultValid);
		end
		latCh = ch;
		latG = g;
		latBy = by;
	endtask : run
	task automatic t_power_up;
		run(3'h5, 3'h7, 1'b0, 14'h0100, 20, 1'b0, 1'b0);
	endtask : t_power_up
	task automatic t_gains;
		for (int g = 0; g < 8; g++) run(3'(g), 3'(g), 1'b0, 14'h03C0, 20, 1'b0, 1'b1);
	endtask : t_gains
	task automatic t_bypass;
		@(posedge core_clk);
		lowPowerSelect <= 1'b1;
		run(3'h2, 3'h3, 1'b1, 14'h3ABC, 20, 1'b0, 1'b1);
		run(3'h6, 3'h1, 1'b0, 14'h2F00, 20, 1'b0, 1'b1);
	endtask : t_bypass
	task automatic t_partial;
		run(3'h1, 3'h2, 1'b0, 14'h1234, 9, 1'b0, 1'b1);
		run(3'h4, 3'h5, 1'b0, 14'h0ABC, 17, 1'b0, 1'b1);
	endtask : t_partial
	task automatic t_abort;
		run(3'h4, 3'h5, 1'b0, 14'h0777, 20, 1'b1, 1'b1);
		run(3'h4, 3'h5, 1'b0, 14'h0222, 20, 1'b0, 1'b1);
	endtask : t_abort
	// reset in mid-run with low-power mode selected: the first result is already valid
	task automatic t_reset_lpm;
		@(posedge core_clk);
		resetn <= 1'b0;
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		latCh = 3'h0;
		latG = 3'h0;
		latBy = 1'b0;
		repeat (6) @(posedge core_clk);
		run(3'h3, 3'h2, 1'b0, 14'h0155, 20, 1'b0, 1'b1);
		run(3'h0, 3'h0, 1'b0, 14'h0A0A, 20, 1'b0, 1'b1);
	endtask : t_reset_lpm
	initial begin
		repeat (3) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (6) @(posedge core_clk);
		t_power_up();
		t_gains();
		t_bypass();
		t_partial();
		t_abort();
		t_reset_lpm();
		test_done();
	end
	// frames take about 5 us each; this leaves wide margin
	initial begin
		#400000;
		miscompares++;
		test_done();
	end
endmodule : tb_sar_adc_serial_readout
